/* File: common/amp_pipe_regs.vh */
/*
 Constants for the arithmetic, multiply and logic pipeline interlock: instruction
 classes, stall counts and per-class stage timelines.
 Assumes a decoder that classifies each instruction in decode before it is issued.
 Bit k of a timeline mask marks an event k+1 cycles after the decode issue cycle.
*/
// Notes on behaviour
// - Status arithmetic runs five stages, idle ma.
// - Status readers wait for pending status writes.
// - Word multiply-accumulate: eight stages, second MA feeds.
// - Multiplier stays busy three cycles after MA.
// - Decode after word multiply-accumulate stalls one slot.
// - Non-multiplier follower proceeds; users wait for multiplier.
// - Multiply memory stages win slots over fetch.
// - Long multiply-accumulate mirrors word form, one stall.
// - DSP variant: word multiply-accumulate has seven stages.
// - DSP variant: long forms have nine stages.
// - 16-bit multiply: six stages, two busy cycles.
// - 16-bit multiply then non-user: no stall.
// - Double multiply: eight stages, busy three, stall one.
// - Register logic: five stages, register write only.
// - Byte memory logic: six stages, stall two slots.
// - Byte memory logic accesses arbitrated against fetch.
// - Byte memory test: seven stages, T at write-back.
// - Test-and-set: three memory stages, T at write-back.
// - DSP variant: test-and-set delays next decode three.
// - Register test: five stages, status at write-back.
`ifndef AMP_PIPE_REGS_VH
`define AMP_PIPE_REGS_VH

`define AMP_TL_DEPTH 9

`define AMP_CLS_REG_ALU 4'h0
`define AMP_CLS_SR_ALU 4'h1
`define AMP_CLS_REG_TEST 4'h2
`define AMP_CLS_MUL_ACC_WORD 4'h3
`define AMP_CLS_MUL_ACC_LONG 4'h4
`define AMP_CLS_MUL16 4'h5
`define AMP_CLS_MUL32X32 4'h6
`define AMP_CLS_MEM_LOGIC 4'h7
`define AMP_CLS_MEM_BYTE_TEST 4'h8
`define AMP_CLS_TEST_SET 4'h9

`define AMP_K_EX 3'h0
`define AMP_K_MA 3'h1
`define AMP_K_MULT 3'h2
`define AMP_K_FEED 3'h3
`define AMP_K_WBR 3'h4
`define AMP_K_WBS 3'h5
`define AMP_K_WBT 3'h6

`define AMP_STALL_MUL 2'h1
`define AMP_STALL_MEM_LOGIC 2'h2
`define AMP_STALL_MEM_TEST 2'h2
`define AMP_STALL_TAS 2'h0
`define AMP_STALL_TAS_DSP 2'h3

`define AMP_M_NONE 9'h000
`define AMP_M_EX1 9'h001
`define AMP_M_EX13 9'h005
`define AMP_M_WB3 9'h004
`define AMP_M_WB5 9'h010
`define AMP_M_MA2 9'h002
`define AMP_M_MA23 9'h006
`define AMP_M_MA24 9'h00a
`define AMP_M_MA234 9'h00e
`define AMP_M_FEED3 9'h004
`define AMP_M_MAC 9'h03c
`define AMP_M_MUL_ACC_WORD_DSP 9'h01c
`define AMP_M_MUL_ACC_LONG_DSP 9'h07c
`define AMP_M_DMUL 9'h03e
`define AMP_M_DMUL_DSP 9'h07e
`define AMP_M_MUL16 9'h00e

`endif

/* File: core/amp_timeline.v */
/*
 Event timeline: a shift register of future single-cycle events for one resource.
 Assumes the owner loads a mask only when it issues an instruction.
*/
`default_nettype none

module amp_timeline #(
   parameter W = 9
) (
   // Clock and reset.
   input wire i_ref_clk,
   input wire i_rst_b,
   input wire i_ce,
   // Candidate schedule.
   input wire i_load,
   input wire [W-1:0] i_mask,
   // Status.
   output wire o_now,
   output wire o_busy,
   output wire o_conflict
);
   reg [W-1:0] tl_r;
   wire [W-1:0] shifted;
   wire [W-1:0] tl_nxt;

   // Shifting never waits on decode, so busy time runs regardless of slots.
   assign shifted = {1'b0, tl_r[W-1:1]};
   assign tl_nxt = i_load ? (shifted | i_mask) : shifted;
   assign o_now = tl_r[0];
   assign o_busy = |tl_r;
   assign o_conflict = |(shifted & i_mask);

   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tl_r <= {W{1'b0}};
      end else if (i_ce) begin
         tl_r <= tl_nxt;
      end
   end
endmodule // amp_timeline

`default_nettype wire

/* File: core/amp_pipe_ctrl.v */
/*
 Decode interlock and stage sequencer for status arithmetic, multiply,
 multiply-accumulate and logic instructions.
 Assumes decode presents one classified instruction and holds it while stalled,
 and that the datapath acts on the stage strobes given here.
*/
`default_nettype none
`include "amp_pipe_regs.vh"

module amp_pipe_ctrl #(
   parameter TLW = `AMP_TL_DEPTH
) (
   // Clock and reset.
   input wire i_ref_clk,
   input wire i_rst_b,
   input wire i_ce,
   // Core variant.
   input wire i_dsp_mode,
   // Decode stage.
   input wire i_id_valid,
   input wire [3:0] i_id_class,
   input wire i_id_wr_reg,
   input wire [3:0] i_id_rn,
   input wire i_id_reads_sr,
   input wire i_id_reads_mac,
   output wire o_id_issue,
   output wire o_id_stall,
   output wire o_sr_hazard,
   output wire o_mult_hazard,
   // Fetch and memory port.
   input wire i_if_req,
   output wire o_if_grant,
   output wire o_ma_req,
   // Stage strobes.
   output wire o_ex_active,
   output wire o_mult_feed,
   output wire o_mult_busy,
   output wire o_wb_reg_we,
   output wire [3:0] o_wb_rn,
   output wire o_wb_sr_we,
   output wire o_wb_t_we
);

   // Timeline of one resource for one instruction class.
   function [TLW-1:0] f_mask;
      input [3:0] cls;
      input [2:0] kind;
      input dsp;
      reg [8:0] m;
      begin
         m = `AMP_M_NONE;
         case (kind)
            `AMP_K_EX: begin
               if (cls == `AMP_CLS_MEM_LOGIC || cls == `AMP_CLS_MEM_BYTE_TEST) begin
                  m = `AMP_M_EX13;
               end else begin
                  m = `AMP_M_EX1;
               end
            end
            `AMP_K_MA: begin
               case (cls)
                  `AMP_CLS_MUL_ACC_WORD: m = `AMP_M_MA23;
                  `AMP_CLS_MUL_ACC_LONG: m = `AMP_M_MA23;
                  `AMP_CLS_MUL32X32: m = `AMP_M_MA23;
                  `AMP_CLS_MUL16: m = `AMP_M_MA2;
                  `AMP_CLS_MEM_LOGIC: m = `AMP_M_MA24;
                  `AMP_CLS_MEM_BYTE_TEST: m = `AMP_M_MA24;
                  `AMP_CLS_TEST_SET: m = `AMP_M_MA234;
                  default: m = `AMP_M_NONE;
               endcase
            end
            `AMP_K_MULT: begin
               case (cls)
                  `AMP_CLS_MUL_ACC_WORD: begin
                     m = dsp ? `AMP_M_MUL_ACC_WORD_DSP : `AMP_M_MAC;
                  end
                  `AMP_CLS_MUL_ACC_LONG: begin
                     m = dsp ? `AMP_M_MUL_ACC_LONG_DSP : `AMP_M_MAC;
                  end
                  `AMP_CLS_MUL32X32: begin
                     m = dsp ? `AMP_M_DMUL_DSP : `AMP_M_DMUL;
                  end
                  `AMP_CLS_MUL16: m = `AMP_M_MUL16;
                  default: m = `AMP_M_NONE;
               endcase
            end
            `AMP_K_FEED: begin
               if (cls == `AMP_CLS_MUL_ACC_WORD || cls == `AMP_CLS_MUL_ACC_LONG) begin
                  m = `AMP_M_FEED3;
               end
            end
            `AMP_K_WBR: begin
               if (cls == `AMP_CLS_REG_ALU || cls == `AMP_CLS_SR_ALU) begin
                  m = `AMP_M_WB3;
               end
            end
            `AMP_K_WBS: begin
               if (cls == `AMP_CLS_SR_ALU || cls == `AMP_CLS_REG_TEST) begin
                  m = `AMP_M_WB3;
               end
            end
            `AMP_K_WBT: begin
               if (cls == `AMP_CLS_MEM_BYTE_TEST || cls == `AMP_CLS_TEST_SET) begin
                  m = `AMP_M_WB5;
               end
            end
            default: m = `AMP_M_NONE;
         endcase
         f_mask = m[TLW-1:0];
      end
   endfunction

   // Slots that the next decode waits behind the issued instruction.
   function [1:0] f_stall;
      input [3:0] cls;
      input dsp;
      begin
         case (cls)
            `AMP_CLS_MUL_ACC_WORD: f_stall = `AMP_STALL_MUL;
            `AMP_CLS_MUL_ACC_LONG: f_stall = `AMP_STALL_MUL;
            `AMP_CLS_MUL32X32: f_stall = `AMP_STALL_MUL;
            `AMP_CLS_MEM_LOGIC: f_stall = `AMP_STALL_MEM_LOGIC;
            `AMP_CLS_MEM_BYTE_TEST: f_stall = `AMP_STALL_MEM_TEST;
            `AMP_CLS_TEST_SET: begin
               f_stall = dsp ? `AMP_STALL_TAS_DSP : `AMP_STALL_TAS;
            end
            default: f_stall = 2'h0;
         endcase
      end
   endfunction

   reg [1:0] stall_cnt_r;
   reg [1:0] stall_cnt_nxt;
   reg [3:0] rn_pipe_r [0:TLW-1];
   reg [3:0] rn_wb_r;
   integer k;

   wire [TLW-1:0] m_ex;
   wire [TLW-1:0] m_ma;
   wire [TLW-1:0] m_mult;
   wire [TLW-1:0] m_feed;
   wire [TLW-1:0] m_wbr;
   wire [TLW-1:0] m_wbs;
   wire [TLW-1:0] m_wbt;
   wire ex_now, ma_now, mult_now, feed_now, wbr_now, wbs_now, wbt_now;
   wire ex_busy, ma_busy, mult_busy, feed_busy, wbr_busy, wbs_busy, wbt_busy;
   wire ex_cf, ma_cf, mult_cf, feed_cf, wbr_cf, wbs_cf, wbt_cf;
   wire sr_haz;
   wire mult_haz;
   wire struct_haz;
   wire stall;
   wire issue;

   assign m_ex = f_mask(i_id_class, `AMP_K_EX, i_dsp_mode);
   assign m_ma = f_mask(i_id_class, `AMP_K_MA, i_dsp_mode);
   assign m_mult = f_mask(i_id_class, `AMP_K_MULT, i_dsp_mode);
   assign m_feed = f_mask(i_id_class, `AMP_K_FEED, i_dsp_mode);
   assign m_wbr = i_id_wr_reg ? f_mask(i_id_class, `AMP_K_WBR, i_dsp_mode) : {TLW{1'b0}};
   assign m_wbs = f_mask(i_id_class, `AMP_K_WBS, i_dsp_mode);
   assign m_wbt = f_mask(i_id_class, `AMP_K_WBT, i_dsp_mode);

   // A status reader waits until every pending status or T write has landed.
   assign sr_haz = i_id_reads_sr & (wbs_busy | wbt_busy);
   // Multiplier users may not overlap multiplier cycles already scheduled.
   assign mult_haz = mult_cf | (i_id_reads_mac & mult_busy);
   assign struct_haz = ex_cf | ma_cf | wbr_cf | wbs_cf | wbt_cf | feed_cf;
   assign stall = (stall_cnt_r != 2'h0) | sr_haz | mult_haz | struct_haz;
   assign issue = i_ce & i_id_valid & ~stall;

   assign o_id_issue = issue;
   assign o_id_stall = i_id_valid & stall;
   assign o_sr_hazard = i_id_valid & sr_haz;
   assign o_mult_hazard = i_id_valid & mult_haz;

   // Memory stages take the port; fetch waits for a free slot.
   assign o_if_grant = i_if_req & ~ma_now;
   assign o_ma_req = ma_now;
   assign o_ex_active = ex_now;
   assign o_mult_feed = feed_now;
   assign o_mult_busy = mult_now;
   assign o_wb_reg_we = wbr_now;
   assign o_wb_rn = rn_wb_r;
   assign o_wb_sr_we = wbs_now;
   assign o_wb_t_we = wbt_now;

   always @* begin
      stall_cnt_nxt = stall_cnt_r;
      if (issue) begin
         stall_cnt_nxt = f_stall(i_id_class, i_dsp_mode);
      end else if (stall_cnt_r != 2'h0) begin
         stall_cnt_nxt = stall_cnt_r - 2'h1;
      end
   end

   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         stall_cnt_r <= 2'h0;
      end else if (i_ce) begin
         stall_cnt_r <= stall_cnt_nxt;
      end
   end

   // Destination tags ride alongside the write-back timeline.
   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         for (k = 0; k < TLW; k = k + 1) begin
            rn_pipe_r[k] <= 4'h0;
         end
         rn_wb_r <= 4'h0;
      end else if (i_ce) begin
         for (k = 0; k < TLW - 1; k = k + 1) begin
            rn_pipe_r[k] <= rn_pipe_r[k+1];
         end
         rn_pipe_r[TLW-1] <= 4'h0;
         if (issue && m_wbr[2]) begin
            rn_pipe_r[2] <= i_id_rn;
         end
         rn_wb_r <= rn_pipe_r[1];
      end
   end

   amp_timeline #(.W(TLW)) u_tl_ex (
      .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
      .i_load(issue), .i_mask(m_ex),
      .o_now(ex_now), .o_busy(ex_busy), .o_conflict(ex_cf)
   );

   amp_timeline #(.W(TLW)) u_tl_ma (
      .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
      .i_load(issue), .i_mask(m_ma),
      .o_now(ma_now), .o_busy(ma_busy), .o_conflict(ma_cf)
   );

   amp_timeline #(.W(TLW)) u_tl_mult (
      .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
      .i_load(issue), .i_mask(m_mult),
      .o_now(mult_now), .o_busy(mult_busy), .o_conflict(mult_cf)
   );

   amp_timeline #(.W(TLW)) u_tl_feed (
      .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
      .i_load(issue), .i_mask(m_feed),
      .o_now(feed_now), .o_busy(feed_busy), .o_conflict(feed_cf)
   );

   amp_timeline #(.W(TLW)) u_tl_wbr (
      .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
      .i_load(issue), .i_mask(m_wbr),
      .o_now(wbr_now), .o_busy(wbr_busy), .o_conflict(wbr_cf)
   );

   amp_timeline #(.W(TLW)) u_tl_wbs (
      .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
      .i_load(issue), .i_mask(m_wbs),
      .o_now(wbs_now), .o_busy(wbs_busy), .o_conflict(wbs_cf)
   );

   amp_timeline #(.W(TLW)) u_tl_wbt (
      .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
      .i_load(issue), .i_mask(m_wbt),
      .o_now(wbt_now), .o_busy(wbt_busy), .o_conflict(wbt_cf)
   );

endmodule // amp_pipe_ctrl

`default_nettype wire

/* File: tb/amp_pipe_properties.sv */
/* Checker for the interlock and stage strobes of the pipeline control.
   Assumes it is bound to the control block; attempts that meet a frozen cycle are dropped. */
`default_nettype none
module amp_pipe_checker #(
   parameter TLW = 9
) (
   // Clock and reset.
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   // Decode and fetch inputs.
   input wire logic i_dsp_mode,
   input wire logic [3:0] i_id_class,
   input wire logic i_id_reads_sr,
   input wire logic i_id_reads_mac,
   input wire logic i_if_req,
   // Watched outputs.
   input wire logic o_id_issue,
   input wire logic o_if_grant,
   input wire logic o_ma_req,
   input wire logic o_mult_feed,
   input wire logic o_mult_busy,
   input wire logic o_wb_t_we
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_b || !i_ce);
   wire logic iss = o_id_issue;
   wire logic is_mac = i_id_class == 4'h3 || i_id_class == 4'h4;
   AST_SR_WAIT: assert property (iss && (i_id_class == 4'h1 || i_id_class == 4'h2)
      |=> !(iss && i_id_reads_sr) [*3]) else $error("status read issued too early");
   AST_MAC_FEED: assert property (iss && is_mac |-> ##2 o_ma_req ##1 (o_ma_req && o_mult_feed))
      else $error("multiply-accumulate memory stages wrong");
   AST_MAC_BUSY: assert property (iss && i_id_class == 4'h3 && !i_dsp_mode
      |-> ##3 o_mult_busy [*4]) else $error("multiplier busy too short");
   AST_MUL_STALL: assert property (iss && (is_mac || i_id_class == 4'h6) |=> !iss)
      else $error("decode not stalled after multiply");
   AST_MUL16: assert property (iss && i_id_class == 4'h5
      |-> ##2 (o_ma_req && o_mult_busy) ##1 o_mult_busy [*2]) else $error("16-bit multiply wrong");
   AST_ML_STALL: assert property (iss && i_id_class == 4'h7 |=> !iss [*2])
      else $error("memory logic stall wrong");
   AST_FETCH: assert property (o_if_grant == (i_if_req && !o_ma_req))
      else $error("fetch grant wrong");
   AST_T_WB: assert property (iss && (i_id_class == 4'h8 || i_id_class == 4'h9)
      |-> ##5 o_wb_t_we) else $error("T write-back missing");
   AST_TAS_DSP: assert property (iss && i_id_class == 4'h9 && i_dsp_mode |=> !iss [*3])
      else $error("test-and-set stall wrong");
   AST_MAC_READ: assert property (o_mult_busy && i_id_reads_mac |-> !iss)
      else $error("multiplier read while busy");
endmodule // amp_pipe_checker
bind amp_pipe_ctrl amp_pipe_checker #(.TLW(TLW)) u_chk (.i_ref_clk, .i_rst_b, .i_ce, .i_dsp_mode,
   .i_id_class, .i_id_reads_sr, .i_id_reads_mac, .i_if_req, .o_id_issue, .o_if_grant,
   .o_ma_req, .o_mult_feed, .o_mult_busy, .o_wb_t_we);
`default_nettype wire

/* File: tb/amp_fetch_model.sv */
/* Fetch unit model that competes with memory stages for the port.
   Assumes the grant is combinational within the cycle. */
`default_nettype none
module amp_fetch_model (
   // Clock.
   input wire logic i_ref_clk,
   // Grant from the pipeline.
   input wire logic i_if_grant,
   // Fetch request.
   output logic o_if_req
);
   timeunit 1ns;
   timeprecision 1ns;
   logic won = 1'b0;
   logic [1:0] cnt = 2'h0;
   initial o_if_req = 1'b0;
   always @(posedge i_ref_clk) won = o_if_req && i_if_grant;
   // A request is held until granted; every fourth grant is followed by a quiet cycle.
   always @(negedge i_ref_clk) begin
      if (won) begin
         cnt = cnt + 2'h1;
         o_if_req = cnt != 2'h0;
      end else begin
         o_if_req = 1'b1;
      end
   end
endmodule // amp_fetch_model
`default_nettype wire

/* File: tb/alu_mult_logic_pipeline_timing_bench.sv */
/* Bench for the pipeline control: scripted pairs and random streams against a strobe model.
   Assumes the fetch model and the bound checker are compiled alongside. */
`default_nettype none
module alu_mult_logic_pipeline_timing_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_ref_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_ce = 1'b1;
   logic ce_q = 1'b1;
   logic i_dsp_mode = 1'b0;
   logic i_id_valid = 1'b0;
   logic i_id_wr_reg = 1'b0;
   logic i_id_reads_sr = 1'b0;
   logic i_id_reads_mac = 1'b0;
   logic [3:0] i_id_class = 4'h0;
   logic [3:0] i_id_rn = 4'h0;
   wire logic i_if_req, o_id_issue, o_id_stall, o_if_grant, o_ma_req, o_ex_active;
   wire logic o_mult_feed, o_mult_busy, o_wb_reg_we, o_wb_sr_we, o_wb_t_we;
   wire logic [3:0] o_wb_rn;
   logic [15:0] ev [0:6] = '{default: 16'h0};
   logic [6:0] ev_now;
   logic [3:0] rn_q [$];
   int fails = 0;
   int total_checks = 0;
   // First class, second class, reads status, reads multiplier, variant, expected wait.
   int tab [19][6] = '{'{1,0,1,0,0,3}, '{2,0,1,0,0,3}, '{0,0,0,0,0,0}, '{1,1,0,0,0,0},
      '{3,0,0,0,0,1}, '{3,5,0,0,0,4}, '{4,0,0,0,0,1}, '{6,0,0,0,0,1}, '{5,0,0,0,0,0},
      '{5,5,0,0,0,2}, '{7,0,0,0,0,2}, '{8,0,1,0,0,5}, '{9,0,0,0,0,0}, '{9,0,1,0,0,5},
      '{9,0,0,0,1,3}, '{3,0,0,0,1,1}, '{4,0,0,0,1,1}, '{6,0,0,0,1,1}, '{6,0,0,1,0,-1}};
   always #50 i_ref_clk = ~i_ref_clk;
   // Remembers whether the last rising edge advanced the design, so the model freezes with it.
   always @(posedge i_ref_clk) ce_q <= i_ce;
   amp_pipe_ctrl #(.TLW(9)) u_dut (.i_ref_clk, .i_rst_b, .i_ce, .i_dsp_mode, .i_id_valid,
      .i_id_class, .i_id_wr_reg, .i_id_rn, .i_id_reads_sr, .i_id_reads_mac, .o_id_issue,
      .o_id_stall, .o_sr_hazard(), .o_mult_hazard(), .i_if_req, .o_if_grant, .o_ma_req,
      .o_ex_active, .o_mult_feed, .o_mult_busy, .o_wb_reg_we, .o_wb_rn, .o_wb_sr_we, .o_wb_t_we);
   amp_fetch_model u_fetch (.i_ref_clk, .i_if_grant(o_if_grant), .o_if_req(i_if_req));
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic idle(input int n);
      i_id_valid = 1'b0;
      repeat (n) @(negedge i_ref_clk);
   endtask
   // Presents one instruction, waits for its issue and schedules the strobes it must cause.
   task automatic run(input int c, input int rs, input int rm, input int ew);
      int w;
      logic d;
      w = 0;
      d = i_dsp_mode;
      i_id_valid = 1'b1;
      i_id_class = 4'(c);
      i_id_reads_sr = 1'(rs);
      i_id_reads_mac = 1'(rm);
      i_id_wr_reg = 1'($urandom);
      i_id_rn = 4'($urandom);
      #10;
      while (o_id_issue !== 1'b1) begin
         chk("stall", o_id_stall, 16'h1);
         w++;
         if (w > 30) begin
            fails++;
            test_done();
         end
         @(negedge i_ref_clk);
         #10;
      end
      if (ew >= 0) chk("wait", 16'(w), 16'(ew));
      ev[0] |= (c == 7 || c == 8) ? 16'ha : 16'h2;
      case (c)
         3, 4, 6: ev[1] |= 16'hc;
         5: ev[1] |= 16'h4;
         7, 8: ev[1] |= 16'h14;
         9: ev[1] |= 16'h1c;
         default: ;
      endcase
      if (c == 3 || c == 4) ev[2] |= 16'h8;
      case (c)
         3: ev[3] |= d ? 16'h38 : 16'h78;
         4: ev[3] |= d ? 16'hf8 : 16'h78;
         5: ev[3] |= 16'h1c;
         6: ev[3] |= d ? 16'hfc : 16'h7c;
         default: ;
      endcase
      if (c <= 1 && i_id_wr_reg) begin
         ev[4] |= 16'h8;
         rn_q.push_back(i_id_rn);
      end
      if (c == 1 || c == 2) ev[5] |= 16'h8;
      if (c == 8 || c == 9) ev[6] |= 16'h20;
      @(negedge i_ref_clk);
   endtask
   always @(negedge i_ref_clk) begin
      #5;
      for (int k = 0; k < 7; k++) begin
         if (ce_q) ev[k] = ev[k] >> 1;
         ev_now[k] = ev[k][0];
      end
      if (i_rst_b) begin
         chk("strobes", {o_wb_t_we, o_wb_sr_we, o_wb_reg_we, o_mult_busy, o_mult_feed, o_ma_req,
            o_ex_active}, ev_now);
         chk("grant", o_if_grant, i_if_req & ~ev_now[1]);
         if (o_wb_reg_we === 1'b1 && rn_q.size() > 0) chk("wb_rn", o_wb_rn, rn_q.pop_front());
      end
   end
   initial begin
      void'($urandom(32'hd0be1ab9));
      repeat (12) @(negedge i_ref_clk);
      i_rst_b = 1'b1;
      @(negedge i_ref_clk);
      foreach (tab[i]) begin
         i_dsp_mode = 1'(tab[i][4]);
         run(tab[i][0], 0, 0, -1);
         run(tab[i][1], tab[i][2], tab[i][3], tab[i][5]);
         idle(10);
         $display("test pair %0d done", i);
      end
      // Clock enable low must hold every strobe where it stands and refuse issue.
      i_dsp_mode = 1'b0;
      run(3, 0, 0, -1);
      i_ce = 1'b0;
      i_id_class = 4'h0;
      repeat (3) begin
         #10;
         chk("frozen", o_id_issue, 16'h0);
         @(negedge i_ref_clk);
      end
      i_ce = 1'b1;
      idle(10);
      $display("test freeze done");
      for (int b = 0; b < 2; b++) begin
         i_dsp_mode = 1'(b);
         repeat (25) run($urandom_range(9), $urandom_range(1), $urandom_range(1), -1);
         idle(10);
         $display("test random %0d done", b);
      end
      test_done();
   end
endmodule // alu_mult_logic_pipeline_timing_bench
`default_nettype wire
